// [logic/seb_pkg.sv]
/*
  Shared constants for the two-wire memory bus front end: device code,
  bit counts, timing counts and the two end state machines.
  Assumes a 125 MHz ref_clk_in on both ends.
*/
package seb_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [3:0] DEV_CODE = 4'h5;          // Arbitrary device-type code
  localparam int STRAP_W = 3;
  localparam int BYTE_W = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;          // Ninth clock, counted from 0
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int MEM_DEPTH = 64;
  localparam int WR_TIME_US = 5000;
  localparam int WR_CYCLES = WR_TIME_US * CLK_MHZ;
  localparam int SCL_HALF_NS = 40;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [2:0] {
    SEB_T_IDLE, SEB_T_ADDR, SEB_T_WRITE, SEB_T_READ, SEB_T_IGNORE
  } seb_tgt_st_t;
  typedef enum logic [2:0] {
    SEB_M_IDLE, SEB_M_START, SEB_M_BIT, SEB_M_STOP_A, SEB_M_STOP_B
  } seb_mst_st_t;
endpackage : seb_pkg

// [logic/seb_if.sv]
/*
  Two-wire bus between controller and target: open-drain clock and data.
  Assumes both ends drive only low; pull-ups resolve here.
*/
`timescale 1ns/1ps
`default_nettype none
interface seb_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_t;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_t);
  modport controller (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport target (output sda_oe_t, input scl, input sda);
endinterface : seb_if
`default_nettype wire

// [logic/seb_fifo.sv]
/*
  Small valid/ready FIFO carrying received write bytes into the array.
  Assumes one clock on both sides.
*/
`timescale 1ns/1ps
`default_nettype none
module seb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_in,          // Clock
  input wire logic rst_in,              // Async reset
  input wire logic in_valid_in,         // Push request
  output logic in_ready_out,            // Not full
  input wire logic [WIDTH-1:0] in_data_in, // Push data
  output logic out_valid_out,           // Not empty
  input wire logic out_ready_in,        // Pop request
  output logic [WIDTH-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_r != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_r[rp_r];
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : seb_fifo
`default_nettype wire

// [logic/seb_target.sv]
/*
  Target end of the two-wire bus: start/stop detection, address match
  against straps, byte receive/transmit with ninth-clock acknowledge,
  write protect and a timed programming cycle into a small array.
  Assumes scl/sda arrive asynchronously from the interface.
*/
// Behaviour
// - Straps give eight selectable target addresses
// - Answer only when strap bits match
// - Open straps read as zero
// - Data line only pulled low or released
// - Act on both serial clock edges
// - Write protect high refuses array writes
// - Array starts as all-ones
// - Start: data falls while clock high
// - No transaction without a start
// - Stop: data rises while clock high
// - Stop during read returns to idle
// - Stop during write with a data byte queued starts programming
// - Transmitter changes data only clock low
// - Data change with clock high is start/stop
// - Eight-bit bytes, receiver acks ninth clock
// - No acknowledge while programming
// - Address is type code, straps, direction
// - Protected write data bytes not acknowledged
`timescale 1ns/1ps
`default_nettype none
module seb_target #(
  parameter int WR_CYCLES = seb_pkg::WR_CYCLES,
  parameter int DEPTH = seb_pkg::MEM_DEPTH
) (
  input wire logic ref_clk_in,        // Clock
  input wire logic rst_in,            // Async reset
  seb_if.target bus,                  // Two-wire bus
  input wire logic addr_strap_bit0,   // Strap, low when open
  input wire logic addr_strap_bit1,   // Strap, low when open
  input wire logic addr_strap_bit2,   // Strap, low when open
  input wire logic write_protect_in,  // High blocks writes
  output logic busy_out               // Programming cycle running
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(WR_CYCLES + 1);
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  logic [2:0] strap_r;
  logic wp_r;
  seb_pkg::seb_tgt_st_t st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [1:0] byte_r;
  logic rd_r, ack_ok_r, sda_oe_r;
  logic [AW-1:0] ptr_r, base_r;
  // Array comes up erased, no reset so it maps to RAM
  logic [7:0] mem_r [DEPTH] = '{default: seb_pkg::ERASED_BYTE};
  logic [CW-1:0] prog_cnt_r;
  logic wr_pend_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic f_ready, f_valid, f_push, drain;
  logic [7:0] f_data;
  // Two-flop sync; logic reads only the second stage onward
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  // Straps and protect are pins too
  logic [2:0] strap_s_r;
  logic wp_s_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s_r <= 3'h0;
      strap_r <= 3'h0;
      wp_s_r <= 1'b0;
      wp_r <= 1'b0;
    end else begin
      strap_s_r <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_r <= strap_s_r;
      wp_s_r <= write_protect_in;
      wp_r <= wp_s_r;
    end
  end
  assign scl_rise = scl_s_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_s_r[1] & scl_d_r;
  assign start_c = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
  assign stop_c = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= seb_pkg::SEB_T_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      byte_r <= 2'h0;
      rd_r <= 1'b0;
      ack_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r <= '0;
      base_r <= '0;
      wr_pend_r <= 1'b0;
    end else if (start_c) begin
      st_r <= seb_pkg::SEB_T_ADDR;
      bit_r <= 4'hf; // Wraps to zero on the fall that follows start
      byte_r <= 2'h0;
      sda_oe_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else if (stop_c) begin
      sda_oe_r <= 1'b0;
      st_r <= seb_pkg::SEB_T_IDLE;
      wr_pend_r <= (st_r == seb_pkg::SEB_T_WRITE) & (f_valid | f_push);
    end else begin
      if (drain) wr_pend_r <= 1'b0;
      case (st_r)
        seb_pkg::SEB_T_IDLE, seb_pkg::SEB_T_IGNORE: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          // Transmit shifter must not take in its own bits
          if (scl_rise && bit_r < seb_pkg::ACK_SLOT && st_r != seb_pkg::SEB_T_READ) begin
            sh_r <= {sh_r[6:0], sda_d_r};
          end
          if (scl_rise && bit_r == seb_pkg::ACK_SLOT && rd_r && sda_d_r) begin
            st_r <= seb_pkg::SEB_T_IGNORE; // Master nack ends the read
          end
          if (scl_fall) begin
            bit_r <= (bit_r == seb_pkg::ACK_SLOT) ? 4'h0 : bit_r + 4'h1;
            sda_oe_r <= 1'b0;
            if (bit_r == 4'h7) begin
              case (st_r)
                seb_pkg::SEB_T_ADDR: begin
                  ack_ok_r <= (sh_r[7:4] == seb_pkg::DEV_CODE)
                    && (sh_r[3:1] == strap_r) && !busy_out;
                  rd_r <= sh_r[0];
                  sda_oe_r <= (sh_r[7:4] == seb_pkg::DEV_CODE)
                    && (sh_r[3:1] == strap_r) && !busy_out;
                end
                seb_pkg::SEB_T_WRITE: begin
                  if (byte_r == 2'h2) begin
                    sda_oe_r <= !wp_r && f_ready;
                  end else begin
                    sda_oe_r <= 1'b1;
                  end
                end
                default: sda_oe_r <= 1'b0;
              endcase
            end else if (bit_r == seb_pkg::ACK_SLOT) begin
              case (st_r)
                seb_pkg::SEB_T_ADDR: begin
                  st_r <= !ack_ok_r ? seb_pkg::SEB_T_IGNORE
                    : (rd_r ? seb_pkg::SEB_T_READ : seb_pkg::SEB_T_WRITE);
                  if (ack_ok_r && rd_r) sda_oe_r <= ~mem_r[ptr_r][7];
                  if (ack_ok_r && rd_r) sh_r <= {mem_r[ptr_r][6:0], 1'b1};
                end
                seb_pkg::SEB_T_WRITE: begin
                  if (byte_r == 2'h1) begin
                    ptr_r <= AW'(sh_r);
                    base_r <= AW'(sh_r);
                    byte_r <= 2'h2;
                  end else if (byte_r == 2'h2) begin
                    ptr_r <= ptr_r + 1'b1;
                  end else begin
                    byte_r <= byte_r + 2'h1;
                  end
                end
                seb_pkg::SEB_T_READ: begin
                  ptr_r <= ptr_r + 1'b1;
                  sda_oe_r <= ~mem_r[ptr_r + 1'b1][7];
                  sh_r <= {mem_r[ptr_r + 1'b1][6:0], 1'b1};
                end
                default: ;
              endcase
            end else if (st_r == seb_pkg::SEB_T_READ) begin
              sda_oe_r <= ~sh_r[7];
              sh_r <= {sh_r[6:0], 1'b1};
            end
          end
        end
      endcase
    end
  end
  assign bus.sda_oe_t = sda_oe_r;
  // Data byte pushed at its ack slot; protected bytes never enter
  assign f_push = (st_r == seb_pkg::SEB_T_WRITE) && byte_r == 2'h2 && scl_fall
    && bit_r == 4'h7 && !wp_r && !start_c && !stop_c;
  seb_fifo #(.WIDTH(seb_pkg::BYTE_W), .DEPTH(seb_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(f_push),
    .in_ready_out(f_ready),
    .in_data_in(sh_r),
    .out_valid_out(f_valid),
    .out_ready_in(drain),
    .out_data_out(f_data)
  );
  // Programming drains FIFO only after stop; full FIFO withholds ack
  assign drain = busy_out && f_valid && prog_cnt_r == CW'(WR_CYCLES);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      prog_cnt_r <= '0;
    end else if (!busy_out) begin
      busy_out <= wr_pend_r;
      prog_cnt_r <= '0;
    end else if (prog_cnt_r != CW'(WR_CYCLES)) begin
      prog_cnt_r <= prog_cnt_r + 1'b1;
    end else if (!f_valid) begin
      busy_out <= 1'b0;
    end
  end
  logic [AW-1:0] wr_at_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) wr_at_r <= '0;
    else if (!busy_out) wr_at_r <= base_r - AW'(0);
    else if (drain) wr_at_r <= wr_at_r + 1'b1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (drain) mem_r[wr_at_r] <= f_data;
  end
endmodule : seb_target
`default_nettype wire

// [logic/seb_controller.sv]
/*
  Controller end: makes the bus clock by a divider, issues start,
  address/data bytes, reads the ninth-clock acknowledge, then stop.
  Assumes user holds request fields stable while req_in is high.
*/
`timescale 1ns/1ps
`default_nettype none
module seb_controller (
  input wire logic ref_clk_in,      // Clock
  input wire logic rst_in,          // Async reset
  seb_if.controller bus,            // Two-wire bus
  input wire logic req_in,          // Start a transfer, level
  input wire logic [7:0] addr_byte_in, // Address byte with direction
  input wire logic [7:0] wdata_in,  // Bytes after address
  input wire logic [1:0] nbytes_in, // Extra bytes to move
  output logic done_out,            // One-cycle end pulse
  output logic nack_out,            // Some sent byte not acknowledged
  output logic [7:0] rdata_out      // Last byte read
);
  localparam int HW = $clog2(seb_pkg::SCL_HALF_CYC + 1);
  seb_pkg::seb_mst_st_t st_r;
  logic [HW-1:0] div_r;
  logic tick, rd_r, scl_oe_r, sda_oe_r;
  logic [3:0] bit_r;
  logic [1:0] left_r;
  logic [7:0] sh_r;
  logic [1:0] sda_s_r;
  assign tick = (div_r == HW'(seb_pkg::SCL_HALF_CYC - 1));
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) div_r <= '0;
    else div_r <= tick ? '0 : div_r + 1'b1;
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) sda_s_r <= 2'h3;
    else sda_s_r <= {sda_s_r[0], bus.sda};
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= seb_pkg::SEB_M_IDLE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      bit_r <= 4'h0;
      left_r <= 2'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      if (tick) begin
        case (st_r)
          seb_pkg::SEB_M_IDLE: if (req_in) begin
            sda_oe_r <= 1'b1;
            st_r <= seb_pkg::SEB_M_START;
            sh_r <= addr_byte_in;
            rd_r <= 1'b0;
            left_r <= nbytes_in;
            nack_out <= 1'b0;
            bit_r <= 4'h0;
          end
          seb_pkg::SEB_M_START: begin
            scl_oe_r <= 1'b1;
            sda_oe_r <= ~sh_r[7];
            st_r <= seb_pkg::SEB_M_BIT;
          end
          seb_pkg::SEB_M_BIT: begin
            if (scl_oe_r) begin // Data already set a whole low phase ago
              scl_oe_r <= 1'b0;
            end else begin
              // Data moves with the falling clock, so it is settled at the rise
              scl_oe_r <= 1'b1;
              bit_r <= (bit_r == seb_pkg::ACK_SLOT) ? 4'h0 : bit_r + 4'h1;
              if (bit_r < seb_pkg::ACK_SLOT) begin
                sh_r <= {sh_r[6:0], sda_s_r[1]};
                if (bit_r == 4'h7) sda_oe_r <= rd_r & (left_r != 2'h0);
                else sda_oe_r <= ~sh_r[6] & ~rd_r;
              end else begin
                if (!rd_r && sda_s_r[1]) nack_out <= 1'b1;
                if (rd_r) rdata_out <= sh_r;
                if (!rd_r && sda_s_r[1] || left_r == 2'h0) begin
                  sda_oe_r <= 1'b1; // Low before the clock rises for stop
                  st_r <= seb_pkg::SEB_M_STOP_A;
                end else begin
                  left_r <= left_r - 2'h1;
                  if (!rd_r && !addr_byte_in[0]) sh_r <= wdata_in;
                  rd_r <= addr_byte_in[0];
                  sda_oe_r <= ~addr_byte_in[0] & ~wdata_in[7];
                end
              end
            end
          end
          seb_pkg::SEB_M_STOP_A: begin
            sda_oe_r <= 1'b1;
            scl_oe_r <= 1'b0;
            st_r <= seb_pkg::SEB_M_STOP_B;
          end
          seb_pkg::SEB_M_STOP_B: begin
            sda_oe_r <= 1'b0;
            done_out <= 1'b1;
            st_r <= seb_pkg::SEB_M_IDLE;
          end
          default: st_r <= seb_pkg::SEB_M_IDLE;
        endcase
      end
    end
  end
  assign bus.scl_oe_m = scl_oe_r;
  assign bus.sda_oe_m = sda_oe_r;
endmodule : seb_controller
`default_nettype wire

// [verif/seb_sva.sv]
/*
  Checker on the two-wire bus between controller and target ends.
  Assumes the resolved levels and pull enables of seb_if, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module seb_checker (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_in,     // Async reset
  input wire logic scl_oe_m,   // Controller clock pull
  input wire logic sda_oe_m,   // Controller data pull
  input wire logic sda_oe_t,   // Target data pull
  input wire logic scl,        // Resolved clock
  input wire logic sda         // Resolved data
);
  logic scl_r;
  logic sda_r;
  logic first_r;
  logic [3:0] cnt_r;
  logic start_ev;
  logic rise_ev;
  assign start_ev = scl & scl_r & sda_r & ~sda;
  assign rise_ev = scl & ~scl_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // Clock rises since start; first_r marks the address byte
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      first_r <= 1'b0;
    end else if (start_ev) begin
      cnt_r <= 4'h0;
      first_r <= 1'b1;
    end else if (rise_ev) begin
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h8) begin
        first_r <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence start_seen;
    scl && $past(scl) && $past(sda) && !sda;
  endsequence
  sequence stop_seen;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence
  // Target answers a falling clock about three cycles late
  sequence high_phase;
    ##[1:12] $rose(scl) ##1 scl [*3];
  endsequence
  a_released_after_reset: assert property ($fell(rst_in) |-> !scl_oe_m && !sda_oe_m && !sda_oe_t)
    else $error("bus not released after reset");
  a_pull_clock_low: assert property ($rose(sda_oe_t) |-> !scl && !sda)
    else $error("target began pulling data with clock high");
  a_target_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe_t))
    else $error("target moved data with clock high");
  a_clk_high_width: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  a_clk_low_width: assert property ($fell(scl) |-> (!scl) [*4])
    else $error("clock low phase too short");
  a_target_bit_hold: assert property ($rose(sda_oe_t) |-> sda_oe_t throughout high_phase)
    else $error("target bit not held over clock high");
  a_quiet_after_start: assert property (start_seen |-> (!sda_oe_t) [*8])
    else $error("target drove data right after start");
  a_quiet_after_stop: assert property (stop_seen |-> (!sda_oe_t) [*8])
    else $error("target drove data right after stop");
  a_addr_ack_slot: assert property (rise_ev && first_r && sda_oe_t |-> cnt_r == 4'h8)
    else $error("address byte pulled outside ninth clock");
endmodule : seb_checker
`default_nettype wire

// [verif/test_serial_eeprom_bus_front_end.sv]
/*
  Bench joining controller and target over seb_if, with a byte model.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_bus_front_end;
  localparam int WR_SIM = 400; // Long enough to poll once mid-cycle
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_in = 1'b0;
  logic [7:0] addr_byte_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [1:0] nbytes_in = 2'h0;
  logic [2:0] strap = 3'h0;
  logic write_protect_in = 1'b0;
  logic done_out;
  logic nack_out;
  logic busy_out;
  logic [7:0] rdata_out;
  logic [7:0] mem [64];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  seb_if bus_if ();
  seb_controller seb_controller_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(bus_if),
    .req_in(req_in), .addr_byte_in(addr_byte_in), .wdata_in(wdata_in), .nbytes_in(nbytes_in),
    .done_out(done_out), .nack_out(nack_out), .rdata_out(rdata_out));
  seb_target #(.WR_CYCLES(WR_SIM), .DEPTH(64)) seb_target_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .bus(bus_if), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .write_protect_in(write_protect_in), .busy_out(busy_out));
  seb_checker seb_checker_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .scl_oe_m(bus_if.scl_oe_m), .sda_oe_m(bus_if.sda_oe_m), .sda_oe_t(bus_if.sda_oe_t),
    .scl(bus_if.scl), .sda(bus_if.sda));
  always #4 ref_clk_in = ~ref_clk_in;
  task automatic stop_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic cmp_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_byte
  function automatic logic [7:0] dev(input logic [2:0] s, input logic rd);
    return {seb_pkg::DEV_CODE, s, rd};
  endfunction : dev
  // Any refused byte raises the controller's nack flag
  function automatic logic exp_nack(input logic [7:0] a, input logic [1:0] n, input logic bsy);
    if (bsy || a[7:4] != seb_pkg::DEV_CODE || a[3:1] != strap) begin
      return 1'b1;
    end
    return n == 2'h3 && !a[0] && write_protect_in;
  endfunction : exp_nack
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic [1:0] n,
                      input logic settle);
    int k;
    @(negedge ref_clk_in);
    addr_byte_in = a;
    wdata_in = d;
    nbytes_in = n;
    req_in = 1'b1;
    k = 0;
    while (done_out !== 1'b1 && k < 5000) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k >= 5000) n_mismatch++;
    req_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    k = 0;
    while (settle && busy_out !== 1'b0 && k < 2000) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k >= 2000) n_mismatch++;
  endtask : xfer
  // Word address and data all equal loc, so the stored byte is loc
  task automatic wr(input logic [7:0] loc);
    xfer(dev(strap, 1'b0), loc, 2'h3, write_protect_in);
    cmp_flag(nack_out, exp_nack(dev(strap, 1'b0), 2'h3, 1'b0));
    if (!write_protect_in) begin
      mem[loc[5:0]] = loc;
      xfer(dev(strap, 1'b1), 8'h00, 2'h1, 1'b1);
      cmp_flag(nack_out, exp_nack(dev(strap, 1'b1), 2'h1, 1'b1));
    end
  endtask : wr
  task automatic rd_chk(input logic [7:0] loc);
    xfer(dev(strap, 1'b0), loc, 2'h2, 1'b1);
    cmp_flag(nack_out, exp_nack(dev(strap, 1'b0), 2'h2, 1'b0));
    xfer(dev(strap, 1'b1), 8'h00, 2'h1, 1'b1);
    cmp_flag(nack_out, 1'b0);
    cmp_byte(rdata_out, mem[loc[5:0]]);
  endtask : rd_chk
  initial begin
    int v;
    int w;
    void'($urandom(45641));
    for (int i = 0; i < 64; i++) begin
      mem[i] = seb_pkg::ERASED_BYTE;
    end
    repeat (4) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      xfer(dev(strap, 1'b1), 8'h00, 2'h1, 1'b1);
      cmp_flag(nack_out, exp_nack(dev(strap, 1'b1), 2'h1, 1'b0));
      xfer(dev(strap ^ 3'h1, 1'b1), 8'h00, 2'h1, 1'b1);
      cmp_flag(nack_out, exp_nack(dev(strap ^ 3'h1, 1'b1), 2'h1, 1'b0));
      xfer({~seb_pkg::DEV_CODE, strap, 1'b1}, 8'h00, 2'h1, 1'b1);
      cmp_flag(nack_out, exp_nack({~seb_pkg::DEV_CODE, strap, 1'b1}, 2'h1, 1'b0));
    end
    $display("test done: strap select");
    strap = 3'($urandom_range(7, 0));
    v = $urandom_range(63, 0);
    w = (v + 1 + $urandom_range(61, 0)) % 64;
    wr(8'(v));
    rd_chk(8'(v));
    rd_chk(8'(w));
    $display("test done: write, poll, read");
    write_protect_in = 1'b1;
    wr(8'(w));
    rd_chk(8'(w));
    write_protect_in = 1'b0;
    wr(8'(w));
    rd_chk(8'(w));
    $display("test done: write protect");
    stop_test();
  end
endmodule : test_serial_eeprom_bus_front_end
`default_nettype wire
